/* rtl/blwp_defs.svh */
// Constants for the backlight serial write port.
// Overview of operation
// - Answer one of two seven-bit addresses, picked by the strap level.
// - Strap low gives write byte 0x72, strap high gives 0x74.
// - Only the acknowledge bit is ever driven onto the data line.
// - Smallest update frame is address, register select, then data.
// - Any number of select and data pairs follow one address match.
// - Transfer ends at STOP, then waits for START; a repeated START goes straight to the address.
// - Address with read flag set is handled exactly like a write.
// - PWM clock is the oscillator divided by 8192, near 160 Hz.
// - Second slow timing clock divided down, programmable about 0.3 to 80 Hz.
// - LED current follows the current setting register loaded over the port.
// - First byte of a pair selects the register, the next is its data.
// - Low nibble selects; selection is not kept across pairs.
// - Codes: 0 shutdown, 1 current, 2-4 dimming, 5-7 PWM, 8-A photo, F test.
// - Current setting holds a five-bit step, upper bits zero, clears at reset.
`ifndef BLWP_DEFS_SVH
`define BLWP_DEFS_SVH
`define BLWP_ADDR_STRAP_LO 7'h39
`define BLWP_ADDR_STRAP_HI 7'h3a
`define BLWP_SEL_SHUTDOWN 4'h0
`define BLWP_SEL_CURRENT 4'h1
`define BLWP_SEL_DIM_UP 4'h2
`define BLWP_SEL_DIM_DOWN 4'h3
`define BLWP_SEL_DIM_TIME 4'h4
`define BLWP_SEL_PWM0 4'h5
`define BLWP_SEL_PWM1 4'h6
`define BLWP_SEL_PWM2 4'h7
`define BLWP_SEL_PH_GAIN 4'h8
`define BLWP_SEL_PH_MIN 4'h9
`define BLWP_SEL_PH_TIME 4'ha
`define BLWP_SEL_FACTORY 4'hf
`define BLWP_STEP_WIDTH 5
`define BLWP_RESET_VALUE 8'h00
`define BLWP_PWM_DIV 8192
`define BLWP_OSC_DIV 16
`define BLWP_SLOW_DIV_MIN 8
`endif

/* rtl/blwp_pkg.sv */
// Types for the backlight serial write port.
package blwp_pkg;
    typedef enum logic [4:0] {
        BLWP_IDLE = 5'b00001,
        BLWP_ADDR = 5'b00010,
        BLWP_SEL = 5'b00100,
        BLWP_DATA = 5'b01000,
        BLWP_SKIP = 5'b10000
    } blwp_state_e;
    typedef struct packed {
        logic [3:0] sel;
        logic [7:0] data;
    } blwp_write_s;
endpackage

/* rtl/blwp_port.sv */
// Serial write-only target port with setting registers and slow clock dividers.
`timescale 1ns/1ps
`include "blwp_defs.svh"
`default_nettype none
module blwp_port
    import blwp_pkg::*;
#(
    parameter int PWM_DIV = `BLWP_PWM_DIV,
    parameter int OSC_DIV = `BLWP_OSC_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_strap_pin,
    input wire logic [7:0] slow_rate,
    output logic shutdown_command,
    output logic [4:0] led_current_setting,
    output logic [7:0] dim_up_target,
    output logic [7:0] dim_down_target,
    output logic [7:0] dim_timing,
    output logic dim_start,
    output logic [7:0] pwm0_setting,
    output logic [7:0] pwm1_setting,
    output logic [7:0] pwm2_setting,
    output logic [7:0] photo_gain,
    output logic [7:0] photo_min,
    output logic [7:0] photo_timing,
    output logic pwm_clock_tick,
    output logic slow_timing_clock
);
    logic rst_m, rst_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_m <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_q <= rst_m;
        end
    end

    // Bus pins pass two flops; the third stage feeds edge detection only.
    logic [1:0] scl_s, sda_s;
    logic scl_d, sda_d;
    always_ff @(posedge clk_sys or negedge rst_q) begin
        if (!rst_q) begin
            scl_s <= 2'b11;
            sda_s <= 2'b11;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    wire scl_rise = scl_s[1] & ~scl_d;
    wire scl_fall = ~scl_s[1] & scl_d;
    wire start_cond = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    wire stop_cond = scl_s[1] & scl_d & ~sda_d & sda_s[1];

    // Strap is caught by a clocked process after release, not by the reset itself.
    // The age count keeps the synchroniser's reset value from passing for the strap level.
    logic [2:0] strap_s;
    logic [1:0] strap_age;
    logic strap_done, strap_level;
    always_ff @(posedge clk_sys or negedge rst_q) begin
        if (!rst_q) begin
            strap_s <= 3'b000;
            strap_age <= 2'd0;
            strap_done <= 1'b0;
            strap_level <= 1'b0;
        end else begin
            strap_s <= {strap_s[1:0], address_strap_pin};
            if (strap_age != 2'd3) begin
                strap_age <= strap_age + 2'd1;
            end
            if (!strap_done && strap_age == 2'd3 && strap_s[2] == strap_s[1]) begin
                strap_done <= 1'b1;
                strap_level <= strap_s[2];
            end
        end
    end
    wire [6:0] my_addr = strap_level ? `BLWP_ADDR_STRAP_HI : `BLWP_ADDR_STRAP_LO;

    blwp_state_e state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic ack_phase;
    logic [3:0] cur_sel;
    logic push_valid;
    blwp_write_s push_word;
    logic buf_in_ready;

    always_ff @(posedge clk_sys or negedge rst_q) begin
        if (!rst_q) begin
            state <= BLWP_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'd0;
            ack_phase <= 1'b0;
            cur_sel <= 4'h0;
            push_valid <= 1'b0;
            push_word <= '0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            if (push_valid && buf_in_ready) begin
                push_valid <= 1'b0;
            end
            if (start_cond) begin
                state <= BLWP_ADDR;
                bit_cnt <= 4'd0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state <= BLWP_IDLE;
                sda_oe <= 1'b0;
            end else if (state != BLWP_IDLE && state != BLWP_SKIP) begin
                if (scl_rise && !ack_phase) begin
                    shift <= {shift[6:0], sda_s[1]};
                    bit_cnt <= bit_cnt + 4'd1;
                end
                if (scl_fall && !ack_phase && bit_cnt == 4'd8) begin
                    ack_phase <= 1'b1;
                    bit_cnt <= 4'd0;
                    unique case (state)
                        BLWP_ADDR: begin
                            // Read flag is ignored: reads act as writes.
                            if (shift[7:1] == my_addr) begin
                                sda_oe <= 1'b1;
                                state <= BLWP_SEL;
                            end else begin
                                state <= BLWP_SKIP;
                                ack_phase <= 1'b0;
                            end
                        end
                        BLWP_SEL: begin
                            cur_sel <= shift[3:0];
                            sda_oe <= 1'b1;
                            state <= BLWP_DATA;
                        end
                        BLWP_DATA: begin
                            // A stalled buffer holds the ack so no pair is dropped.
                            sda_oe <= 1'b1;
                            push_valid <= 1'b1;
                            push_word <= '{sel: cur_sel, data: shift};
                            state <= BLWP_SEL;
                        end
                        default: state <= BLWP_IDLE;
                    endcase
                end else if (scl_fall && ack_phase && !(push_valid && !buf_in_ready)) begin
                    ack_phase <= 1'b0;
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    // Two-entry buffer between the byte engine and the setting registers.
    logic [1:0] buf_cnt;
    blwp_write_s buf_mem [2];
    logic wr_ptr, rd_ptr;
    wire buf_out_valid = buf_cnt != 2'd0;
    wire buf_out_ready = 1'b1;
    assign buf_in_ready = buf_cnt != 2'd2;
    wire buf_push = push_valid && buf_in_ready;
    wire buf_pop = buf_out_valid && buf_out_ready;
    always_ff @(posedge clk_sys or negedge rst_q) begin
        if (!rst_q) begin
            buf_cnt <= 2'd0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (buf_push) begin
                buf_mem[wr_ptr] <= push_word;
                wr_ptr <= ~wr_ptr;
            end
            if (buf_pop) begin
                rd_ptr <= ~rd_ptr;
            end
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end
    blwp_write_s head;
    assign head = buf_mem[rd_ptr];

    always_ff @(posedge clk_sys or negedge rst_q) begin
        if (!rst_q) begin
            shutdown_command <= 1'b0;
            led_current_setting <= 5'h00;
            dim_up_target <= `BLWP_RESET_VALUE;
            dim_down_target <= `BLWP_RESET_VALUE;
            dim_timing <= `BLWP_RESET_VALUE;
            dim_start <= 1'b0;
            pwm0_setting <= `BLWP_RESET_VALUE;
            pwm1_setting <= `BLWP_RESET_VALUE;
            pwm2_setting <= `BLWP_RESET_VALUE;
            photo_gain <= `BLWP_RESET_VALUE;
            photo_min <= `BLWP_RESET_VALUE;
            photo_timing <= `BLWP_RESET_VALUE;
        end else begin
            dim_start <= 1'b0;
            if (buf_pop) begin
                unique case (head.sel)
                    `BLWP_SEL_SHUTDOWN: shutdown_command <= 1'b1;
                    `BLWP_SEL_CURRENT: begin
                        shutdown_command <= 1'b0;
                        led_current_setting <= head.data[4:0];
                    end
                    `BLWP_SEL_DIM_UP: dim_up_target <= head.data;
                    `BLWP_SEL_DIM_DOWN: dim_down_target <= head.data;
                    `BLWP_SEL_DIM_TIME: begin
                        dim_timing <= head.data;
                        dim_start <= 1'b1;
                    end
                    `BLWP_SEL_PWM0: pwm0_setting <= head.data;
                    `BLWP_SEL_PWM1: pwm1_setting <= head.data;
                    `BLWP_SEL_PWM2: pwm2_setting <= head.data;
                    `BLWP_SEL_PH_GAIN: photo_gain <= head.data;
                    `BLWP_SEL_PH_MIN: photo_min <= head.data;
                    `BLWP_SEL_PH_TIME: photo_timing <= head.data;
                    default: begin
                        // Reserved and factory-test codes leave all settings alone.
                    end
                endcase
            end
        end
    end

    // Oscillator stand-in: clk_sys divided by OSC_DIV gives the converter tick.
    logic [15:0] osc_cnt;
    logic osc_tick;
    logic [15:0] pwm_cnt;
    logic [15:0] slow_cnt;
    always_ff @(posedge clk_sys or negedge rst_q) begin
        if (!rst_q) begin
            osc_cnt <= 16'h0000;
            osc_tick <= 1'b0;
            pwm_cnt <= 16'h0000;
            pwm_clock_tick <= 1'b0;
            slow_cnt <= 16'h0000;
            slow_timing_clock <= 1'b0;
        end else begin
            osc_tick <= osc_cnt == 16'(OSC_DIV - 1);
            osc_cnt <= (osc_cnt == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_cnt + 16'h0001;
            pwm_clock_tick <= 1'b0;
            if (osc_tick) begin
                pwm_clock_tick <= pwm_cnt == 16'(PWM_DIV - 1);
                pwm_cnt <= (pwm_cnt == 16'(PWM_DIV - 1)) ? 16'h0000 : pwm_cnt + 16'h0001;
                // Half period in PWM ticks, so the rate is 80/(slow_rate+1) Hz.
                if (pwm_cnt == 16'(PWM_DIV - 1)) begin
                    if (slow_cnt >= {8'h00, slow_rate}) begin
                        slow_cnt <= 16'h0000;
                        slow_timing_clock <= ~slow_timing_clock;
                    end else begin
                        slow_cnt <= slow_cnt + 16'h0001;
                    end
                end
            end
        end
    end

    AST_ACK_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_q)
        sda_oe |-> (sda_out == 1'b0 && ack_phase))
        else $error("data line driven outside acknowledge");
    AST_STOP_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_q)
        stop_cond && !start_cond |=> state == BLWP_IDLE)
        else $error("stop did not end transfer");
    AST_STRAP_HELD: assert property (@(posedge clk_sys) disable iff (!rst_q)
        $past(strap_done) |-> $stable(strap_level))
        else $error("strap changed after capture");
    AST_CUR_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_q)
        buf_pop && head.sel == `BLWP_SEL_CURRENT |=> led_current_setting == $past(head.data[4:0]))
        else $error("current setting not loaded");
    AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_q)
        buf_pop && head.sel >= 4'hb |=> $stable(led_current_setting) && $stable(pwm0_setting))
        else $error("reserved code changed a setting");
    AST_PAIR: assert property (@(posedge clk_sys) disable iff (!rst_q)
        state == BLWP_DATA && scl_fall && !ack_phase && bit_cnt == 4'd8 && !start_cond && !stop_cond
        |=> push_valid && state == BLWP_SEL)
        else $error("data byte not queued");
    AST_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_q)
        state == BLWP_ADDR && scl_fall && !ack_phase && bit_cnt == 4'd8 && !start_cond && !stop_cond
        && shift[7:1] == my_addr |=> sda_oe)
        else $error("own address not acknowledged");
    AST_PWM_TICK: assert property (@(posedge clk_sys) disable iff (!rst_q)
        pwm_clock_tick |=> !pwm_clock_tick)
        else $error("pwm tick longer than one cycle");

    sequence sel_end_q;
        state == BLWP_SEL && scl_fall && !ack_phase && bit_cnt == 4'd8 && !start_cond && !stop_cond;
    endsequence
    sequence ack_taken_q;
        sda_oe && scl_fall && !start_cond && !stop_cond && !(push_valid && !buf_in_ready);
    endsequence
    AST_SEL_ACK: assert property (@(posedge clk_sys) disable iff (!rst_q)
        sel_end_q |=> sda_oe && state == BLWP_DATA)
        else $error("select byte not acknowledged");
    AST_ACK_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_q)
        ack_taken_q |=> !sda_oe && !ack_phase)
        else $error("data line held past acknowledge");
endmodule
`default_nettype wire

/* test/blwp_master.sv */
// Bus master model that sends write frames to the port over an open-drain data line.
`timescale 1ns/1ps
`default_nettype none
module blwp_master (
    input wire logic clk_sys,
    input wire logic sda_out,
    input wire logic sda_oe,
    output logic scl_in,
    output logic sda_in
);
    logic sda_m = 1'b1;
    logic in_ack = 1'b0;
    int n_bad = 0;
    // The pull-up wins whenever nobody pulls the data line low.
    assign sda_in = sda_m & ~(sda_oe & ~sda_out);
    initial scl_in = 1'b1;
    always @(negedge clk_sys) begin
        if (sda_oe === 1'b1 && !in_ack) n_bad++;
    end
    // Three quarters of 13 cycles per data bit keep the serial clock near 513 kHz.
    task automatic q();
        repeat (13) @(negedge clk_sys);
    endtask
    task automatic rel();
        q();
        in_ack = 1'b0;
    endtask
    task automatic start();
        sda_m = 1'b1;
        rel();
        scl_in = 1'b1;
        q();
        sda_m = 1'b0;
        q();
        scl_in = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_m = 1'b0;
        rel();
        scl_in = 1'b1;
        q();
        sda_m = 1'b1;
        q();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_m = b[i];
            if (i == 7) rel();
            else q();
            scl_in = 1'b1;
            q();
            q();
            if (i == 0) in_ack = 1'b1;
            scl_in = 1'b0;
        end
        q();
        sda_m = 1'b1;
        q();
        scl_in = 1'b1;
        q();
        ack = ~sda_in;
        q();
        scl_in = 1'b0;
    endtask
    // A byte clocked without any START before it.
    task automatic loose(input logic [7:0] b, output logic ack);
        scl_in = 1'b0;
        q();
        wbyte(b, ack);
    endtask
endmodule
`default_nettype wire

/* test/blwp_port_tb.sv */
// Self-checking bench for the backlight serial write port.
`timescale 1ns/1ps
`default_nettype none
module blwp_port_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b0;
    logic [7:0] slow_rate = 8'h01;
    logic sda_out, sda_oe, scl_in, sda_in, shutdown, dim_start, tick, slow, slow_q;
    logic [4:0] cur;
    logic [7:0] r [2:10];
    logic [7:0] e [0:10];
    logic [31:0] rs = 32'h0000001b;
    int n_errors = 0;
    int tests_run = 0;
    int c0 = 0;
    int n_dim = 0;
    int n_seen = 0;
    int gap = 0;
    int tk = 0;
    int cyc = 0;
    logic seen_t = 1'b0;
    logic seen_s = 1'b0;
    blwp_port #(.PWM_DIV(4), .OSC_DIV(2)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pin(strap),
        .slow_rate(slow_rate), .shutdown_command(shutdown), .led_current_setting(cur),
        .dim_up_target(r[2]), .dim_down_target(r[3]), .dim_timing(r[4]), .dim_start(dim_start),
        .pwm0_setting(r[5]), .pwm1_setting(r[6]), .pwm2_setting(r[7]), .photo_gain(r[8]),
        .photo_min(r[9]), .photo_timing(r[10]), .pwm_clock_tick(tick), .slow_timing_clock(slow));
    blwp_master m (.clk_sys(clk_sys), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in),
        .sda_in(sda_in));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (exp !== got) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            print_verdict();
        end
    end
    // Ticks are counted between slow clock edges, so a toggle on a tick cycle is still exact.
    always @(negedge clk_sys) begin
        gap++;
        if (dim_start === 1'b1) n_seen++;
        if (!rstn) begin
            seen_t = 1'b0;
            seen_s = 1'b0;
        end else begin
            if (slow !== slow_q) begin
                if (seen_s) chk("slow_half", slow_rate + 1, tk);
                seen_s = 1'b1;
                tk = 0;
            end
            if (tick === 1'b1) begin
                if (seen_t) chk("tick_gap", 8, gap);
                seen_t = 1'b1;
                gap = 0;
                tk++;
            end
        end
        slow_q = slow;
    end
    task automatic apply(input logic [3:0] c, input logic [7:0] d);
        if (c == 4'h0) e[0] = 8'h01;
        if (c == 4'h1) begin
            e[0] = 8'h00;
            e[1] = {3'h0, d[4:0]};
        end
        if (c == 4'h4) n_dim++;
        if (c >= 4'h2 && c <= 4'ha) e[c] = d;
    endtask
    task automatic check_regs();
        chk("shutdown", e[0], {7'h00, shutdown});
        chk("current", e[1], {3'h0, cur});
        for (int i = 2; i <= 10; i++) chk("setting", e[i], r[i]);
        chk("dim_pulses", n_dim, n_seen);
    endtask
    task automatic do_reset(input logic s);
        logic [31:0] rv;
        rstn = 1'b0;
        strap = s;
        rv = xs();
        slow_rate = {6'h00, rv[1:0]};
        for (int i = 0; i <= 10; i++) e[i] = 8'h00;
        repeat (4) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (8) @(negedge clk_sys);
        check_regs();
    endtask
    // Codes walk 0 to E across frames, each with a random upper nibble.
    task automatic frame(input logic [7:0] adr, input int np, input logic hit);
        logic a;
        logic [31:0] rv;
        logic [7:0] s;
        m.start();
        m.wbyte(adr, a);
        chk("addr_ack", hit, a);
        for (int k = 0; k < np; k++) begin
            rv = xs();
            s = {rv[7:4], 4'((c0 + k) % 15)};
            m.wbyte(s, a);
            chk("sel_ack", hit, a);
            m.wbyte(rv[15:8], a);
            chk("data_ack", hit, a);
            if (hit) apply(s[3:0], rv[15:8]);
        end
        if (hit) c0 = (c0 + np) % 15;
        m.stop();
        repeat (6) @(negedge clk_sys);
        check_regs();
    endtask
    initial begin
        logic a;
        do_reset(1'b0);
        frame(8'h72, 1, 1'b1);
        frame(8'h73, 8, 1'b1);
        frame(8'h74, 2, 1'b0);
        m.loose(8'h01, a);
        chk("loose_ack", 0, a);
        m.wbyte(8'h1f, a);
        chk("loose_ack", 0, a);
        frame(8'h72, 8, 1'b1);
        do_reset(1'b1);
        frame(8'h72, 1, 1'b0);
        strap = 1'b0;
        frame(8'h75, 3, 1'b1);
        frame(8'h74, 4, 1'b1);
        chk("stray_drive", 0, m.n_bad);
        print_verdict();
    end
endmodule
`default_nettype wire
